/* File: hw/acc_pkg.sv */
package acc_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [11:0] OFF_START_TRIGGER    = 12'h000;
  localparam logic [11:0] OFF_HALT_TRIGGER     = 12'h004;
  localparam logic [11:0] OFF_CAPTURE_TRIGGER  = 12'h008;
  localparam logic [11:0] OFF_READY_FLAG       = 12'h100;
  localparam logic [11:0] OFF_FALLING_FLAG     = 12'h104;
  localparam logic [11:0] OFF_RISING_FLAG      = 12'h108;
  localparam logic [11:0] OFF_ANY_EDGE_FLAG    = 12'h10C;
  localparam logic [11:0] OFF_EVENT_TASK_LINKS = 12'h200;
  localparam logic [11:0] OFF_IRQ_ENABLE       = 12'h300;
  localparam logic [11:0] OFF_IRQ_ENABLE_SET   = 12'h304;
  localparam logic [11:0] OFF_IRQ_ENABLE_CLEAR = 12'h308;
  localparam logic [11:0] OFF_COMPARE_OUTCOME  = 12'h400;
  localparam logic [11:0] OFF_BLOCK_ON         = 12'h500;
  localparam logic [11:0] OFF_POS_INPUT_SEL    = 12'h504;
  localparam logic [11:0] OFF_REFERENCE_SOURCE = 12'h508;
  localparam logic [11:0] OFF_EXT_REF_PIN      = 12'h50C;
  localparam logic [11:0] OFF_LADDER_THRESH    = 12'h530;
  localparam logic [11:0] OFF_OPERATING_CONFIG = 12'h534;
  localparam logic [11:0] OFF_DIFF_HYSTERESIS  = 12'h538;

  // ==========================================================================
  // Field layouts
  // ==========================================================================
  localparam int LOWER_FIELD_LSB = 0;   // lower_ladder_field bits 5:0
  localparam int UPPER_FIELD_LSB = 8;   // upper_ladder_field bits 13:8
  localparam int SPEED_LSB       = 0;   // speed field bits 1:0
  localparam int MAIN_MODE_BIT   = 8;   // 0 single-ended, 1 differential
  localparam int LADDER_W        = 6;   // 64 ladder levels
  // event_task_links bit positions
  localparam int LINK_READY_SAMPLE = 0;
  localparam int LINK_READY_STOP   = 1;
  localparam int LINK_DOWN_STOP    = 2;
  localparam int LINK_UP_STOP      = 3;
  localparam int LINK_ANY_EDGE_EVENT_STOP   = 4;
  // Event bit positions in irq enable
  localparam int EV_READY = 0;
  localparam int EV_DOWN  = 1;
  localparam int EV_UP    = 2;
  localparam int EV_ANY_EDGE_EVENT = 3;
  localparam int EV_N     = 4;

  // ==========================================================================
  // Reset values and encodings
  // ==========================================================================
  localparam logic [2:0] REF_INT_1V2     = 3'h0;
  localparam logic [2:0] REF_INT_1V8     = 3'h1;
  localparam logic [2:0] REF_INT_2V4     = 3'h2;
  localparam logic [2:0] REF_SUPPLY      = 3'h4;
  localparam logic [2:0] REF_EXT_OPTION  = 3'h5;
  localparam logic [2:0] REF_RESET       = REF_SUPPLY;
  localparam logic [2:0] POS_HALF_SUPPLY = 3'h7;
  localparam logic [1:0] BLOCK_ON_VALUE  = 2'h2;   // enable encoding
  localparam logic [5:0] LADDER_RESET    = 6'h00;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_MHZ          = 50;
  localparam int STARTUP_NS       = 1000;  // comparator start-up interval
  localparam int STARTUP_CYCLES   = (STARTUP_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    ACC_IDLE    = 2'b00,
    ACC_WARMING = 2'b01,
    ACC_RUNNING = 2'b10
  } acc_state_t;

  // Analog front-end steering, carried together
  typedef struct packed {
    logic       powerOn;      // acquire pins, run core
    logic [2:0] posSelect;    // positive_input mux
    logic       diffMode;     // negative_input from pin
    logic [2:0] extRefPin;    // external_reference_pin
    logic [2:0] refSource;    // reference_source
    logic [5:0] ladderTap;    // active ladder tap
    logic       hystOn;       // differential hysteresis
    logic [1:0] speed;        // speed/power mode
  } acc_analog_t;

  // Event pulses, carried together
  typedef struct packed {
    logic any_edge_event;
    logic up;
    logic down;
    logic ready;
  } acc_events_t;

endpackage

/* File: hw/acc_control.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - When enabled, writing one to start runs, writing one to halt stops.
// - After the start-up interval following start, raise the ready event.
// - While running, every crossing of positive over negative input gives events.
// - Below-to-above raises up, above-to-below down; both raise any_edge_event.
// - Capture task copies the present comparator output into the result register.
// - Positive select picks inputs 0..6 or half supply, in both modes.
// - Differential mode takes negative input from pin chosen by external select.
// - Differential hysteresis: switch only beyond negative input plus/minus half window.
// - Single-ended negative input is a 64-level ladder tap set by thresholds.
// - Output above selects lower tap; output below selects upper tap.
// - Single-ended mode ignores the hysteresis enable register.
// - External reference option uses the external select pin as reference.
// - Result reads 0 when below, 1 when above.
// - Reference codes 0,1,2 internal, 4 supply, 5 external; reset 4.
// - Links: ready to sample or stop; down, up, any_edge_event to stop.
// - Writing one to irq-enable-set enables that event; read returns enables.
module acc_control #(
  parameter int STARTUP_CNT = acc_pkg::STARTUP_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 compRaw,
  output acc_pkg::acc_analog_t      analogCtl,
  output acc_pkg::acc_events_t      eventPulse,
  output logic                      irqReq
);
  import acc_pkg::*;

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [1:0]        blockOn_ff;
  logic [2:0]        posSel_ff;
  logic [2:0]        refSrc_ff;
  logic [2:0]        extRef_ff;
  logic [5:0]        upperTh_ff;
  logic [5:0]        lowerTh_ff;
  logic              diffMode_ff;
  logic [1:0]        speed_ff;
  logic              hyst_ff;
  logic [4:0]        links_ff;
  logic [EV_N-1:0]   irqEn_ff;
  logic [EV_N-1:0]   evFlag_ff;
  logic              result_ff;
  acc_state_t        state_ff;
  logic [15:0]       warmCnt_ff;
  logic              syncA_ff;
  logic              syncB_ff;
  logic              prevOut_ff;
  logic [31:0]       prdata_ff;
  logic              pready_ff;
  logic              slverr_ff;
  acc_analog_t       analog_ff;
  acc_events_t       evPulse_ff;
  logic              irq_ff;

  logic              wrAcc;
  logic              rdAcc;
  logic              enabled;
  logic              startTask;
  logic              stopTask;
  logic              sampleTask;
  logic              readyEv;
  logic              upEv;
  logic              downEv;
  logic              crossEv;
  logic              mapped;
  logic [EV_N-1:0]   evSet;
  logic [31:0]       nxt_prdata;

  // ==========================================================================
  // APB decode: one wait state; a write lands at the completing edge
  // ==========================================================================
  assign wrAcc   = psel && penable && pwrite && pready_ff;
  assign rdAcc   = psel && penable && !pwrite && !pready_ff;
  assign enabled = (blockOn_ff == BLOCK_ON_VALUE);

  // Tasks fire on a written one in bit 0
  // task triggers
  assign startTask  = wrAcc && paddr == OFF_START_TRIGGER && pwdata[0] && enabled;
  assign stopTask   = (wrAcc && paddr == OFF_HALT_TRIGGER && pwdata[0])
                    || (readyEv && links_ff[LINK_READY_STOP])
                    || (downEv && links_ff[LINK_DOWN_STOP])
                    || (upEv && links_ff[LINK_UP_STOP])
                    || (crossEv && links_ff[LINK_ANY_EDGE_EVENT_STOP]);
  assign sampleTask = (wrAcc && paddr == OFF_CAPTURE_TRIGGER && pwdata[0])
                    || (readyEv && links_ff[LINK_READY_SAMPLE]);

  // Pready is a registered pulse so the answer comes one cycle after access
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_ff <= 1'b0;
      slverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      slverr_ff <= psel && penable && !pready_ff && !mapped;
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      blockOn_ff  <= 2'h0;
      posSel_ff   <= 3'h0;
      refSrc_ff   <= REF_RESET;
      extRef_ff   <= 3'h0;
      upperTh_ff  <= LADDER_RESET;
      lowerTh_ff  <= LADDER_RESET;
      diffMode_ff <= 1'b0;
      speed_ff    <= 2'h0;
      hyst_ff     <= 1'b0;
      links_ff    <= 5'h00;
    end else if (wrAcc) begin
      case (paddr)
        OFF_BLOCK_ON:         blockOn_ff <= pwdata[1:0];
        OFF_POS_INPUT_SEL:    posSel_ff <= pwdata[2:0];
        OFF_REFERENCE_SOURCE: refSrc_ff <= pwdata[2:0];
        OFF_EXT_REF_PIN:      extRef_ff <= pwdata[2:0];
        OFF_LADDER_THRESH: begin
          lowerTh_ff <= pwdata[LOWER_FIELD_LSB +: LADDER_W];
          upperTh_ff <= pwdata[UPPER_FIELD_LSB +: LADDER_W];
        end
        OFF_OPERATING_CONFIG: begin
          speed_ff    <= pwdata[SPEED_LSB +: 2];
          diffMode_ff <= pwdata[MAIN_MODE_BIT];
        end
        // stored, but unused in single-ended mode
        OFF_DIFF_HYSTERESIS:  hyst_ff <= pwdata[0];
        OFF_EVENT_TASK_LINKS: links_ff <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  // Interrupt enables: plain, set and clear views
  // enable set
  always_ff @(posedge clk) begin
    if (rst) begin
      irqEn_ff <= '0;
    end else if (wrAcc && paddr == OFF_IRQ_ENABLE) begin
      irqEn_ff <= pwdata[EV_N-1:0];
    end else if (wrAcc && paddr == OFF_IRQ_ENABLE_SET) begin
      irqEn_ff <= irqEn_ff | pwdata[EV_N-1:0];
    end else if (wrAcc && paddr == OFF_IRQ_ENABLE_CLEAR) begin
      irqEn_ff <= irqEn_ff & ~pwdata[EV_N-1:0];
    end
  end

  // ==========================================================================
  // Run state and start-up interval
  // ==========================================================================
  // warm-up then ready
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff   <= ACC_IDLE;
      warmCnt_ff <= 16'h0000;
    end else if (!enabled || stopTask) begin
      state_ff   <= ACC_IDLE;
      warmCnt_ff <= 16'h0000;
    end else begin
      case (state_ff)
        ACC_IDLE: begin
          if (startTask) begin
            state_ff   <= ACC_WARMING;
            warmCnt_ff <= 16'h0000;
          end
        end
        ACC_WARMING: begin
          warmCnt_ff <= warmCnt_ff + 16'h0001;
          if (warmCnt_ff == 16'(STARTUP_CNT - 1)) begin
            state_ff <= ACC_RUNNING;
          end
        end
        ACC_RUNNING: state_ff <= ACC_RUNNING;
        default:     state_ff <= ACC_IDLE;
      endcase
    end
  end

  assign readyEv = (state_ff == ACC_WARMING) && (warmCnt_ff == 16'(STARTUP_CNT - 1));

  // ==========================================================================
  // Comparator output: synchroniser and edge events
  // ==========================================================================
  // two-stage sync
  always_ff @(posedge clk) begin
    if (rst) begin
      syncA_ff <= 1'b0;
      syncB_ff <= 1'b0;
    end else begin
      syncA_ff <= compRaw;
      syncB_ff <= syncA_ff;
    end
  end

  // Reference for edges tracks the synchronised output every cycle, whether running or not
  always_ff @(posedge clk) begin
    if (rst) begin
      prevOut_ff <= 1'b0;
    end else begin
      prevOut_ff <= syncB_ff;
    end
  end

  assign upEv    = (state_ff == ACC_RUNNING) && syncB_ff && !prevOut_ff;
  assign downEv  = (state_ff == ACC_RUNNING) && !syncB_ff && prevOut_ff;
  assign crossEv = upEv || downEv;
  assign evSet   = {crossEv, upEv, downEv, readyEv};

  // Sticky event flags; a set in the clearing cycle wins
  // sticky flags
  generate
    for (genvar i = 0; i < EV_N; i++) begin : g_flag
      always_ff @(posedge clk) begin
        if (rst) begin
          evFlag_ff[i] <= 1'b0;
        end else if (evSet[i]) begin
          evFlag_ff[i] <= 1'b1;
        end else if (wrAcc && paddr == (OFF_READY_FLAG + 12'(4 * i)) && !pwdata[0]) begin
          evFlag_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      result_ff <= 1'b0;
    end else if (sampleTask) begin
      result_ff <= syncB_ff;
    end
  end

  // ==========================================================================
  // Analog steering
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      analog_ff <= '0;
    end else begin
      analog_ff.powerOn   <= enabled && (state_ff != ACC_IDLE);
      analog_ff.posSelect <= posSel_ff;
      analog_ff.diffMode  <= diffMode_ff;
      analog_ff.extRefPin <= extRef_ff;
      analog_ff.refSource <= refSrc_ff;
      analog_ff.ladderTap <= syncB_ff ? lowerTh_ff : upperTh_ff;
      analog_ff.hystOn    <= diffMode_ff && hyst_ff;
      analog_ff.speed     <= speed_ff;
    end
  end

  // Event pulses and interrupt request
  always_ff @(posedge clk) begin
    if (rst) begin
      evPulse_ff <= '0;
      irq_ff     <= 1'b0;
    end else begin
      evPulse_ff <= {crossEv, upEv, downEv, readyEv};
      irq_ff     <= |(evFlag_ff & irqEn_ff);
    end
  end

  // ==========================================================================
  // Read mux
  // ==========================================================================
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    mapped     = 1'b1;
    case (paddr)
      OFF_START_TRIGGER, OFF_HALT_TRIGGER, OFF_CAPTURE_TRIGGER: nxt_prdata = 32'h0000_0000;
      OFF_READY_FLAG:       nxt_prdata[0] = evFlag_ff[EV_READY];
      OFF_FALLING_FLAG:     nxt_prdata[0] = evFlag_ff[EV_DOWN];
      OFF_RISING_FLAG:      nxt_prdata[0] = evFlag_ff[EV_UP];
      OFF_ANY_EDGE_FLAG:    nxt_prdata[0] = evFlag_ff[EV_ANY_EDGE_EVENT];
      OFF_EVENT_TASK_LINKS: nxt_prdata[4:0] = links_ff;
      OFF_IRQ_ENABLE, OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLEAR:
        nxt_prdata[EV_N-1:0] = irqEn_ff;
      OFF_COMPARE_OUTCOME:  nxt_prdata[0] = result_ff;
      OFF_BLOCK_ON:         nxt_prdata[1:0] = blockOn_ff;
      OFF_POS_INPUT_SEL:    nxt_prdata[2:0] = posSel_ff;
      OFF_REFERENCE_SOURCE: nxt_prdata[2:0] = refSrc_ff;
      OFF_EXT_REF_PIN:      nxt_prdata[2:0] = extRef_ff;
      OFF_LADDER_THRESH: begin
        nxt_prdata[LOWER_FIELD_LSB +: LADDER_W] = lowerTh_ff;
        nxt_prdata[UPPER_FIELD_LSB +: LADDER_W] = upperTh_ff;
      end
      OFF_OPERATING_CONFIG: begin
        nxt_prdata[SPEED_LSB +: 2]  = speed_ff;
        nxt_prdata[MAIN_MODE_BIT]   = diffMode_ff;
      end
      OFF_DIFF_HYSTERESIS:  nxt_prdata[0] = hyst_ff;
      default:              mapped = 1'b0;
    endcase
  end

  // Read data registered on the access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rdAcc) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = slverr_ff;
  assign analogCtl  = analog_ff;
  assign eventPulse = evPulse_ff;
  assign irqReq     = irq_ff;

endmodule

/* File: sim/acc_analog_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// Analog pins, reference sources and comparator core
// ==========================================================================
module acc_analog_model #(
  parameter int VDD_MV  = 3000,
  parameter int HYST_MV = 50
) (
  input  wire logic                 clk,
  input  wire acc_pkg::acc_analog_t analogCtl,
  output logic                      compRaw
);
  import acc_pkg::*;
  int pinMv [8];
  int vp;
  int vn;
  int vref;

  initial begin
    compRaw = 1'b0;
    foreach (pinMv[k]) pinMv[k] = 0;
  end

  // Core decides on the falling edge, away from the sampling edge
  always @(negedge clk) begin
    case (analogCtl.refSource)
      REF_INT_1V2:    vref = 1200;
      REF_INT_1V8:    vref = 1800;
      REF_INT_2V4:    vref = 2400;
      REF_EXT_OPTION: vref = pinMv[analogCtl.extRefPin];
      default:        vref = VDD_MV;
    endcase
    // positive pick / differential pick / ladder
    vp = (analogCtl.posSelect == POS_HALF_SUPPLY) ? VDD_MV / 2 : pinMv[analogCtl.posSelect];
    vn = analogCtl.diffMode ? pinMv[analogCtl.extRefPin] : vref * (analogCtl.ladderTap + 1) / 64;
    // Unpowered core output wanders, so stray edges must be ignored
    if (!analogCtl.powerOn) begin
      compRaw <= ~compRaw;
    end else if (analogCtl.diffMode && analogCtl.hystOn) begin
      if (vp > vn + HYST_MV / 2) compRaw <= 1'b1;
      else if (vp < vn - HYST_MV / 2) compRaw <= 1'b0;
    end else begin
      compRaw <= (vp > vn);
    end
  end
endmodule

/* File: sim/acc_control_checker.sv */
`timescale 1ns/1ps
// ==========================================================================
// Bus and event checks
// ==========================================================================
module acc_control_checker #(
  parameter int STARTUP_CNT = acc_pkg::STARTUP_CYCLES
) (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire acc_pkg::acc_analog_t analogCtl,
  input wire acc_pkg::acc_events_t eventPulse
);
  import acc_pkg::*;
  logic       take;
  logic [7:0] warmCnt_ff;
  logic [5:0] loTap_ff;
  logic [5:0] hiTap_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Write completes at this edge
  assign take = psel && penable && pready && pwrite;

  // Cycles since last start write; saturates so stale counts never match
  always_ff @(posedge clk) begin
    if (rst) warmCnt_ff <= 8'hFF;
    else if (take && paddr == OFF_START_TRIGGER && pwdata[0]) warmCnt_ff <= 8'h00;
    else if (warmCnt_ff != 8'hFF) warmCnt_ff <= warmCnt_ff + 8'h01;
  end

  // Ladder taps as last written
  always_ff @(posedge clk) begin
    if (rst) begin
      loTap_ff <= 6'h00;
      hiTap_ff <= 6'h00;
    end else if (take && paddr == OFF_LADDER_THRESH) begin
      loTap_ff <= pwdata[5:0];
      hiTap_ff <= pwdata[13:8];
    end
  end

  a_one_wait_state: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an answer");
  a_any_edge_event_single: assert property (eventPulse.any_edge_event |=> !eventPulse.any_edge_event)
    else $error("any_edge_event pulse longer than one cycle");
  a_dir_with_any_edge_event: assert property (eventPulse.up || eventPulse.down |-> eventPulse.any_edge_event)
    else $error("direction event without any_edge_event");
  a_ready_timing: assert property (eventPulse.ready |-> warmCnt_ff >= STARTUP_CNT && warmCnt_ff <= STARTUP_CNT + 2)
    else $error("ready event off its start-up slot");
  a_tap_lower: assert property (eventPulse.up && !analogCtl.diffMode |-> ##[0:3] analogCtl.ladderTap == loTap_ff)
    else $error("ladder not on lower tap after up");
  a_tap_upper: assert property (eventPulse.down && !analogCtl.diffMode |-> ##[0:3] analogCtl.ladderTap == hiTap_ff)
    else $error("ladder not on upper tap after down");
  a_hyst_ignored: assert property (analogCtl.powerOn && !analogCtl.diffMode |-> !analogCtl.hystOn)
    else $error("hysteresis on in single-ended mode");
endmodule

bind acc_control acc_control_checker #(.STARTUP_CNT(STARTUP_CNT)) i_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .analogCtl(analogCtl), .eventPulse(eventPulse));

/* File: sim/tb_analog_comparator_control.sv */
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench
// ==========================================================================
module tb_analog_comparator_control;
  import acc_pkg::*;
  localparam int SU = 6;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        compRaw;
  acc_analog_t analogCtl;
  acc_events_t eventPulse;
  logic        irqReq;
  logic [31:0] rd;
  logic        er;
  logic        hi;
  logic        nw;
  int          errors = 0;
  int          compares = 0;
  int          cycles = 0;
  int          p;
  int          mv;
  int          corner [4] = '{1921, 1922, 985, 984};
  logic [2:0]  codes [5] = '{REF_INT_1V2, REF_INT_1V8, REF_INT_2V4, REF_EXT_OPTION, REF_SUPPLY};

  acc_control #(.STARTUP_CNT(SU)) i_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .compRaw(compRaw),
    .analogCtl(analogCtl), .eventPulse(eventPulse), .irqReq(irqReq));
  acc_analog_model i_far (.clk(clk), .analogCtl(analogCtl), .compRaw(compRaw));

  // Clock
  always #10 clk = ~clk;

  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] want);
    xfer(a, 1'b0, 32'h0);
    check(rd, want);
  endtask

  task automatic setPin(input int k, input int v);
    i_far.pinMv[k] = v;
    repeat (10) @(posedge clk);
  endtask

  // Read each event flag, then clear it; bit order ready, down, up, any_edge_event
  task automatic flags(input logic [3:0] want);
    for (int k = 0; k < 4; k++) begin
      rdc(OFF_READY_FLAG + 12'(4 * k), {31'h0, want[k]});
      wr(OFF_READY_FLAG + 12'(4 * k), 32'h0);
    end
  endtask

  function automatic logic above(input int v, input int tap);
    return v > 3000 * (tap + 1) / 64;
  endfunction

  initial begin
    void'($urandom(32'hD4C8));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc(OFF_REFERENCE_SOURCE, 32'h4);
    xfer(12'h600, 1'b0, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    // Start refused while the block is off
    wr(OFF_START_TRIGGER, 32'h1);
    repeat (SU + 8) @(posedge clk);
    flags(4'h0);
    for (int k = 0; k < 5; k++) begin
      wr(OFF_REFERENCE_SOURCE, {29'h0, codes[k]});
      rdc(OFF_REFERENCE_SOURCE, {29'h0, codes[k]});
      check({29'h0, analogCtl.refSource}, {29'h0, codes[k]});
    end
    // Single-ended, taps 40 and 20 over the supply; hysteresis write must not matter
    wr(OFF_POS_INPUT_SEL, 32'h0);
    wr(OFF_EXT_REF_PIN, 32'h7);
    wr(OFF_LADDER_THRESH, 32'h2814);
    wr(OFF_OPERATING_CONFIG, 32'h1);
    wr(OFF_DIFF_HYSTERESIS, 32'h1);
    wr(OFF_IRQ_ENABLE_SET, 32'hF);
    rdc(OFF_IRQ_ENABLE_SET, 32'hF);
    wr(OFF_BLOCK_ON, 32'h2);
    wr(OFF_START_TRIGGER, 32'h1);
    repeat (SU + 8) @(posedge clk);
    check({31'h0, irqReq}, 32'h1);
    check({31'h0, analogCtl.hystOn}, 32'h0);
    check({31'h0, analogCtl.powerOn}, 32'h1);
    check({30'h0, analogCtl.speed}, 32'h1);
    flags(4'h1);
    check({31'h0, irqReq}, 32'h0);
    hi = 1'b0;
    for (int i = 0; i < 12; i++) begin
      mv = (i < 4) ? corner[i] : int'($urandom % 3000);
      nw = above(mv, hi ? 20 : 40);
      setPin(0, mv);
      flags((nw != hi) ? {1'b1, nw, !nw, 1'b0} : 4'h0);
      hi = nw;
      check({26'h0, analogCtl.ladderTap}, hi ? 32'h14 : 32'h28);
      wr(OFF_CAPTURE_TRIGGER, 32'h1);
      rdc(OFF_COMPARE_OUTCOME, {31'h0, hi});
    end
    // Differential: random positive pin against pin 7, hysteresis still on
    wr(OFF_HALT_TRIGGER, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, analogCtl.powerOn}, 32'h0);
    wr(OFF_BLOCK_ON, 32'h0);
    p = int'($urandom % 7);
    wr(OFF_POS_INPUT_SEL, 32'(p));
    wr(OFF_OPERATING_CONFIG, 32'h100);
    setPin(7, 1500);
    setPin(p, 1000);
    wr(OFF_BLOCK_ON, 32'h2);
    wr(OFF_START_TRIGGER, 32'h1);
    repeat (SU + 8) @(posedge clk);
    flags(4'h1);
    check({29'h0, analogCtl.posSelect}, 32'(p));
    check({29'h0, analogCtl.extRefPin}, 32'h7);
    check({31'h0, analogCtl.hystOn}, 32'h1);
    setPin(p, 1510);
    flags(4'h0);
    setPin(p, 1600);
    flags(4'hC);
    setPin(p, 1490);
    flags(4'h0);
    setPin(p, 1400);
    flags(4'hA);
    wr(OFF_CAPTURE_TRIGGER, 32'h1);
    rdc(OFF_COMPARE_OUTCOME, 32'h0);
    // Up event halts the core; later crossings stay silent
    wr(OFF_EVENT_TASK_LINKS, 32'(1 << LINK_UP_STOP));
    setPin(p, 1600);
    flags(4'hC);
    setPin(p, 1400);
    flags(4'h0);
    // Ready event fires a capture
    setPin(p, 1600);
    wr(OFF_EVENT_TASK_LINKS, 32'(1 << LINK_READY_SAMPLE));
    wr(OFF_START_TRIGGER, 32'h1);
    repeat (SU + 8) @(posedge clk);
    rdc(OFF_COMPARE_OUTCOME, 32'h1);
    // Clear view drops only the written enable
    wr(OFF_IRQ_ENABLE_CLEAR, 32'h1);
    rdc(OFF_IRQ_ENABLE, 32'hE);
    wrap_up();
  end
endmodule
